/* dte_buf.sv */
// Small valid/ready buffer holding read data until it is written out.
// Assumes both sides run on clk; depth two by default.
`timescale 1ns/100ps
module dte_buf #(
  parameter int W     = 32,
  parameter int DEPTH = 2
) (
  input  logic         clk,
  input  logic         nrst,
  input  logic         in_valid,
  output logic         in_ready,
  input  logic [W-1:0] in_data,
  output logic         out_valid,
  input  logic         out_ready,
  output logic [W-1:0] out_data
);
  import dte_pkg::*;

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0]   FULL = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wr;
    logic [AW-1:0]           rd;
    logic [AW:0]             cnt;
  } dte_buf_st_t;

  dte_buf_st_t s_reg;
  dte_buf_st_t s_next;
  logic        push;
  logic        pop;

  function automatic logic [AW-1:0] wrap(input logic [AW-1:0] p);
    wrap = (p == LAST) ? '0 : p + AW'(1);
  endfunction : wrap

  assign in_ready  = (s_reg.cnt != FULL);
  assign out_valid = (s_reg.cnt != '0);
  assign out_data  = s_reg.mem[s_reg.rd];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    if (push) begin
      s_next.mem[s_reg.wr] = in_data;
      s_next.wr = wrap(s_reg.wr);
    end
    if (pop) begin
      s_next.rd = wrap(s_reg.rd);
    end
    if (push && !pop) begin
      s_next.cnt = s_reg.cnt + (AW+1)'(1);
    end else if (pop && !push) begin
      s_next.cnt = s_reg.cnt - (AW+1)'(1);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

endmodule : dte_buf

/* dte_core.sv */
// Descriptor transfer engine: activation, descriptor fetch, data move, write-back.
// Assumes activations and the memory bus are on clk; bus answers via mem_ack.
`timescale 1ns/100ps
module dte_core (
  input  logic               clk,
  input  logic               nrst,
  input  logic               act_valid,
  input  logic [7:0]         act_vector,
  output logic               act_ready,
  input  logic [31:0]        vector_base,
  input  logic               read_skip_enable,
  output logic               mem_req,
  output logic               mem_we,
  output logic [31:0]        mem_addr,
  output dte_pkg::dte_size_t mem_size,
  output logic [31:0]        mem_wdata,
  input  logic               mem_ack,
  input  logic [31:0]        mem_rdata,
  output logic               cpu_irq,
  output logic               busy
);
  import dte_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    dte_state_t  st;
    logic [7:0]  vec;
    logic [7:0]  pvec;
    logic        pvalid;
    logic        pchain;
    logic        chained;
    logic [31:0] dbase;
    logic [1:0]  idx;
    dte_desc_t   d;
    logic [8:0]  rd_left;
    logic [8:0]  wr_left;
    logic        bus;
    logic        inwr;
    logic        zero;
    logic        irq;
  } dte_core_st_t;

  dte_core_st_t s_reg;
  dte_core_st_t s_next;

  dte_cmd_t    cmd;
  logic        cmd_valid;
  logic        cmd_ready;
  logic        rsp_valid;
  logic [31:0] rsp_data;
  logic        buf_in_valid;
  logic        buf_in_ready;
  logic        buf_out_valid;
  logic        buf_out_ready;
  logic [31:0] buf_out_data;
  logic        do_wr;
  logic        do_rd;
  logic [31:0] dar_n;

  // ---------------------------------------------------------------
  // Descriptor fields
  // ---------------------------------------------------------------
  dte_xmode_t  xmode;
  dte_size_t   dsz;
  logic [1:0]  sam;
  logic [1:0]  dam;
  logic        ce;
  logic        coz;
  logic        irqsel;
  logic        dts;
  logic [7:0]  reload;
  logic [8:0]  rl_n;
  logic [8:0]  units;

  assign xmode  = dte_xmode_t'(s_reg.d.mra[MODE_LSB +: 2]);
  assign dsz    = dte_size_t'(s_reg.d.mra[SIZE_LSB +: 2]);
  assign sam    = s_reg.d.mra[SAM_LSB +: 2];
  assign dam    = s_reg.d.mode_reg_b[DAM_LSB +: 2];
  assign ce     = s_reg.d.mode_reg_b[CHAIN_BIT];
  assign coz    = s_reg.d.mode_reg_b[ZCHAIN_BIT];
  assign irqsel = s_reg.d.mode_reg_b[IRQSEL_BIT];
  assign dts    = s_reg.d.mode_reg_b[AREA_BIT];
  assign reload = s_reg.d.tca[15:8];
  assign rl_n   = reload_count(reload);
  assign units  = (xmode == XM_BLOCK) ? rl_n : 9'h001;

  assign act_ready = (s_reg.st == ST_IDLE);
  assign busy      = (s_reg.st != ST_IDLE);
  assign cpu_irq   = s_reg.irq;

  // ---------------------------------------------------------------
  // Sub-blocks
  // ---------------------------------------------------------------
  dte_split u_split (
    .clk       (clk),
    .nrst      (nrst),
    .cmd_valid (cmd_valid),
    .cmd       (cmd),
    .cmd_ready (cmd_ready),
    .rsp_valid (rsp_valid),
    .rsp_data  (rsp_data),
    .mem_req   (mem_req),
    .mem_we    (mem_we),
    .mem_addr  (mem_addr),
    .mem_size  (mem_size),
    .mem_wdata (mem_wdata),
    .mem_ack   (mem_ack),
    .mem_rdata (mem_rdata)
  );

  dte_buf #(
    .W     (32),
    .DEPTH (2)
  ) u_buf (
    .clk       (clk),
    .nrst      (nrst),
    .in_valid  (buf_in_valid),
    .in_ready  (buf_in_ready),
    .in_data   (rsp_data),
    .out_valid (buf_out_valid),
    .out_ready (buf_out_ready),
    .out_data  (buf_out_data)
  );

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.irq = 1'b0;
    cmd_valid = 1'b0;
    cmd = '0;
    buf_in_valid = 1'b0;
    buf_out_ready = 1'b0;
    do_wr = buf_out_valid && (!buf_in_ready || s_reg.rd_left == 9'h000);
    do_rd = !do_wr && s_reg.rd_left != 9'h000 && buf_in_ready;
    dar_n = addr_step(s_reg.d.destination_address_reg, dam, dsz);
    if (!read_skip_enable) begin
      s_next.pvalid = 1'b0;
    end
    unique case (s_reg.st)
      ST_IDLE: begin
        if (act_valid) begin
          s_next.vec = act_vector;
          s_next.chained = 1'b0;
          if (read_skip_enable && s_reg.pvalid && !s_reg.pchain && act_vector == s_reg.pvec) begin
            s_next.st = ST_DATA;
            s_next.rd_left = units;
            s_next.wr_left = units;
          end else begin
            s_next.st = ST_VEC;
          end
        end
      end
      ST_VEC: begin
        cmd_valid = !s_reg.bus;
        cmd.addr = vector_base + {22'h0, s_reg.vec, 2'h0};
        cmd.size = SZ_LONG;
        if (rsp_valid) begin
          s_next.dbase = rsp_data;
          s_next.idx = 2'h0;
          s_next.st = ST_DESC;
        end
      end
      ST_DESC: begin
        cmd_valid = !s_reg.bus;
        cmd.addr = s_reg.dbase + {28'h0, s_reg.idx, 2'h0};
        cmd.size = SZ_LONG;
        if (rsp_valid) begin
          unique case (s_reg.idx)
            2'h0: begin
              s_next.d.mra = rsp_data[MRA_LSB +: 8];
              s_next.d.mode_reg_b = rsp_data[MRB_LSB +: 8];
            end
            2'h1: s_next.d.source_address_reg = rsp_data;
            2'h2: s_next.d.destination_address_reg = rsp_data;
            2'h3: begin
              s_next.d.tca = rsp_data[TCA_LSB +: 16];
              s_next.d.btc = rsp_data[15:0];
            end
          endcase
          s_next.idx = s_reg.idx + 2'h1;
          if (s_reg.idx == DESC_LAST) begin
            s_next.st = ST_DATA;
            if (xmode == XM_BLOCK) begin
              s_next.rd_left = reload_count(rsp_data[RELOAD_LSB +: 8]);
            end else begin
              s_next.rd_left = 9'h001;
            end
            s_next.wr_left = s_next.rd_left;
          end
        end
      end
      ST_DATA: begin
        cmd.size = dsz;
        if (!s_reg.bus && do_wr) begin
          cmd_valid = 1'b1;
          cmd.we = 1'b1;
          cmd.addr = s_reg.d.destination_address_reg;
          cmd.wdata = buf_out_data;
          buf_out_ready = cmd_ready;
          s_next.inwr = 1'b1;
        end else if (!s_reg.bus && do_rd) begin
          cmd_valid = 1'b1;
          cmd.addr = s_reg.d.source_address_reg;
          s_next.inwr = 1'b0;
        end
        if (rsp_valid && !s_reg.inwr) begin
          buf_in_valid = 1'b1;
          s_next.rd_left = s_reg.rd_left - 9'h001;
          s_next.d.source_address_reg = addr_step(s_reg.d.source_address_reg, sam, dsz);
        end
        if (rsp_valid && s_reg.inwr) begin
          s_next.wr_left = s_reg.wr_left - 9'h001;
          s_next.d.destination_address_reg = dar_n;
          if (s_reg.wr_left == 9'h001) begin
            s_next.st = ST_WB;
            s_next.idx = 2'h0;
            if (xmode == XM_BLOCK || (xmode == XM_REPEAT && s_reg.d.tca[7:0] == 8'h01)) begin
              if (dts) begin
                s_next.d.source_address_reg = addr_restore(s_reg.d.source_address_reg, sam, dsz, rl_n);
              end else begin
                s_next.d.destination_address_reg = addr_restore(dar_n, dam, dsz, rl_n);
              end
            end
            case (xmode)
              XM_REPEAT: begin
                if (s_reg.d.tca[7:0] == 8'h01) begin
                  s_next.d.tca[7:0] = reload;
                  s_next.zero = 1'b1;
                end else begin
                  s_next.d.tca[7:0] = s_reg.d.tca[7:0] - 8'h01;
                  s_next.zero = 1'b0;
                end
              end
              XM_BLOCK: begin
                s_next.d.tca[7:0] = reload;
                s_next.d.btc = s_reg.d.btc - 16'h0001;
                s_next.zero = (s_reg.d.btc == 16'h0001);
              end
              default: begin
                s_next.d.tca = s_reg.d.tca - 16'h0001;
                s_next.zero = (s_reg.d.tca == 16'h0001);
              end
            endcase
          end
        end
      end
      ST_WB: begin
        cmd_valid = !s_reg.bus;
        cmd.we = 1'b1;
        cmd.size = SZ_LONG;
        cmd.addr = s_reg.dbase + {28'h0, s_reg.idx, 2'h0};
        unique case (s_reg.idx)
          2'h0: cmd.wdata = {s_reg.d.mra, s_reg.d.mode_reg_b, 16'h0000};
          2'h1: cmd.wdata = s_reg.d.source_address_reg;
          2'h2: cmd.wdata = s_reg.d.destination_address_reg;
          2'h3: cmd.wdata = {s_reg.d.tca, s_reg.d.btc};
        endcase
        if (rsp_valid) begin
          s_next.idx = s_reg.idx + 2'h1;
          if (s_reg.idx == DESC_LAST) begin
            s_next.st = ST_DONE;
          end
        end
      end
      ST_DONE: begin
        if (ce && (!coz || s_reg.zero)) begin
          s_next.st = ST_DESC;
          s_next.dbase = s_reg.dbase + DESC_STRIDE;
          s_next.idx = 2'h0;
          s_next.chained = 1'b1;
        end else begin
          s_next.irq = !ce && (irqsel || s_reg.zero);
          s_next.pvec = s_reg.vec;
          s_next.pvalid = read_skip_enable;
          s_next.pchain = s_reg.chained;
          s_next.st = ST_IDLE;
        end
      end
      default: begin
        s_next.st = ST_IDLE;
      end
    endcase
    if (cmd_valid && cmd_ready) begin
      s_next.bus = 1'b1;
    end
    if (rsp_valid) begin
      s_next.bus = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

endmodule : dte_core

/* dte_core_props.sv */
// Checker on the engine's activation and bus ports.
// Assumes one clock domain, nrst asynchronous active low.
`timescale 1ns/100ps
module dte_core_props (
  input wire logic               clk,
  input wire logic               nrst,
  input wire logic               act_valid,
  input wire logic [7:0]         act_vector,
  input wire logic               act_ready,
  input wire logic [31:0]        vector_base,
  input wire logic               read_skip_enable,
  input wire logic               mem_req,
  input wire logic               mem_we,
  input wire logic [31:0]        mem_addr,
  input wire dte_pkg::dte_size_t mem_size,
  input wire logic [31:0]        mem_wdata,
  input wire logic               mem_ack,
  input wire logic [31:0]        mem_rdata,
  input wire logic               cpu_irq,
  input wire logic               busy
);
  import dte_pkg::*;
  logic [31:0] vec_reg;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) vec_reg <= 32'h0;
    else if (act_valid && act_ready) vec_reg <= vector_base + {22'h0, act_vector, 2'h0};
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_irq_idle: assert property (busy |-> !cpu_irq && !act_ready)
    else $error("irq or ready while busy");
  a_take_busy: assert property (act_valid && act_ready |=> busy)
    else $error("activation not started");
  a_vector_fetch: assert property (act_valid && act_ready && !read_skip_enable |=> ##[1:2]
    (mem_req && !mem_we && mem_size == SZ_LONG && mem_addr == vec_reg)) else $error("no vector fetch");
  a_req_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr)
    && $stable(mem_we) && $stable(mem_size) && $stable(mem_wdata)) else $error("bus cycle not held");
  a_bus_align: assert property (mem_req |-> !(mem_size == SZ_WORD && mem_addr[0])
    && !(mem_size == SZ_LONG && mem_addr[1:0] != 2'h0)) else $error("misaligned bus cycle");
  a_ack_gap: assert property (mem_ack |=> !mem_req || $changed(mem_addr))
    else $error("bus cycle repeated after ack");
  a_idle_quiet: assert property (!busy |-> !mem_req)
    else $error("bus cycle while idle");
  a_irq_end: assert property (cpu_irq |-> (!busy && $past(busy)) ##1 !cpu_irq)
    else $error("irq not a pulse at end");
  c_irq: cover property (cpu_irq);
  c_odd_byte: cover property (mem_req && mem_size == SZ_BYTE && mem_addr[0]);
  c_write: cover property (mem_ack && mem_we);
endmodule : dte_core_props
bind dte_core dte_core_props props_u (.clk(clk), .nrst(nrst), .act_valid(act_valid), .act_vector(act_vector),
  .act_ready(act_ready), .vector_base(vector_base), .read_skip_enable(read_skip_enable), .mem_req(mem_req),
  .mem_we(mem_we), .mem_addr(mem_addr), .mem_size(mem_size), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
  .mem_rdata(mem_rdata), .cpu_irq(cpu_irq), .busy(busy));

/* dte_core_tb.sv */
// Self-checking bench for the engine core with a memory partner.
// Assumes the checker bind and memory model are compiled first.
`timescale 1ns/100ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
  $display("MISMATCH %s expected %h seen %h", n, e, g); end end
module dte_core_tb;
  import dte_pkg::*;
  logic        clk, nrst, act_valid, act_ready, read_skip_enable;
  logic        mem_req, mem_we, mem_ack, cpu_irq, busy, irq_seen;
  logic [7:0]  act_vector;
  logic [31:0] vector_base, mem_addr, mem_wdata, mem_rdata;
  logic [1:0]  slow;
  dte_size_t   mem_size;
  int          num_errors, tests_run, ack_cnt, cyc;
  dte_core dut_u (.clk(clk), .nrst(nrst), .act_valid(act_valid), .act_vector(act_vector), .act_ready(act_ready),
    .vector_base(vector_base), .read_skip_enable(read_skip_enable), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_size(mem_size), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .cpu_irq(cpu_irq), .busy(busy));
  dte_mem_model mem_u (.clk(clk), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_size(mem_size),
    .mem_wdata(mem_wdata), .slow(slow), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (mem_ack === 1'b1) ack_cnt++;
    if (cpu_irq === 1'b1) irq_seen = 1'b1;
    if (cyc == 20000) begin
      num_errors++;
      report_and_stop();
    end
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic wl(input logic [31:0] a, input logic [31:0] v);
    for (int k = 0; k < 4; k++) mem_u.mem[a[9:0] + k] = v[8*k +: 8];
  endtask : wl
  function automatic logic [31:0] rl(input logic [31:0] a);
    for (int k = 0; k < 4; k++) rl[8*k +: 8] = mem_u.mem[a[9:0] + k];
  endfunction : rl
  task automatic desc(input logic [31:0] a, input logic [7:0] ma, input logic [7:0] mb, input logic [31:0] c);
    wl(a, {ma, mb, 16'h0});
    wl(a + 32'h4, 32'h300);
    wl(a + 32'h8, 32'h340);
    wl(a + 32'hC, c);
  endtask : desc
  task automatic run;
    int n;
    @(posedge clk);
    ack_cnt = 0;
    irq_seen = 1'b0;
    act_valid <= 1'b1;
    @(posedge clk);
    act_valid <= 1'b0;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (busy !== 1'b0 && n < 600);
    @(negedge clk);
    if (n >= 600) num_errors++;
  endtask : run
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_normal;
    desc(32'h200, 8'h08, 8'h08, 32'h0002_0000);
    mem_u.mem[10'h300] = 8'hA5;
    mem_u.mem[10'h301] = 8'h5A;
    run();
    `CHK("copy", 8'hA5, mem_u.mem[10'h340])
    `CHK("sar", 32'h301, rl(32'h204))
    `CHK("dar", 32'h341, rl(32'h208))
    `CHK("count", 32'h0001_0000, rl(32'h20C))
    `CHK("irq", 1'b0, irq_seen)
    `CHK("cycles", 11, ack_cnt)
    run();
    `CHK("copy2", 8'h5A, mem_u.mem[10'h341])
    `CHK("irq2", 1'b1, irq_seen)
  endtask : t_normal
  task automatic t_split;
    desc(32'h200, 8'h28, 8'h0C, 32'h0001_0000);
    wl(32'h204, 32'h301);
    wl(32'h208, 32'h342);
    wl(32'h300, 32'h4433_2211);
    wl(32'h304, 32'h8877_6655);
    run();
    `CHK("long", 32'h5544_3322, rl(32'h342))
    `CHK("cycles", 14, ack_cnt)
    `CHK("sar", 32'h305, rl(32'h204))
    `CHK("dar", 32'h33E, rl(32'h208))
  endtask : t_split
  task automatic t_repeat;
    desc(32'h200, 8'h48, 8'h18, 32'h0301_0000);
    wl(32'h204, 32'h302);
    run();
    `CHK("area", 32'h300, rl(32'h204))
    `CHK("dar", 32'h341, rl(32'h208))
    `CHK("reload", 32'h0303_0000, rl(32'h20C))
  endtask : t_repeat
  task automatic t_block;
    slow = 2'h2;
    desc(32'h200, 8'hA8, 8'h08, 32'h0202_0001);
    wl(32'h300, 32'h1111_1111);
    wl(32'h304, 32'h2222_2222);
    run();
    `CHK("unit0", 32'h1111_1111, rl(32'h340))
    `CHK("unit1", 32'h2222_2222, rl(32'h344))
    `CHK("sar", 32'h308, rl(32'h204))
    `CHK("area", 32'h340, rl(32'h208))
    `CHK("counts", 32'h0202_0000, rl(32'h20C))
    `CHK("irq", 1'b1, irq_seen)
    `CHK("cycles", 13, ack_cnt)
    slow = 2'h0;
  endtask : t_block
  task automatic t_chain;
    desc(32'h200, 8'h08, 8'h88, 32'h0005_0000);
    desc(32'h210, 8'h08, 8'h28, 32'h0005_0000);
    wl(32'h214, 32'h310);
    wl(32'h218, 32'h350);
    mem_u.mem[10'h300] = 8'h3C;
    mem_u.mem[10'h310] = 8'hC3;
    run();
    `CHK("first", 8'h3C, mem_u.mem[10'h340])
    `CHK("second", 8'hC3, mem_u.mem[10'h350])
    `CHK("irq", 1'b1, irq_seen)
    `CHK("cycles", 21, ack_cnt)
  endtask : t_chain
  task automatic t_skip;
    desc(32'h200, 8'h08, 8'h08, 32'h0005_0000);
    @(posedge clk);
    read_skip_enable <= 1'b1;
    run();
    `CHK("after chain", 11, ack_cnt)
    run();
    `CHK("skipped", 6, ack_cnt)
    `CHK("sar", 32'h302, rl(32'h204))
    @(posedge clk);
    read_skip_enable <= 1'b0;
    @(posedge clk);
    read_skip_enable <= 1'b1;
    run();
    `CHK("refetch", 11, ack_cnt)
    wl(32'h118, 32'h200);
    @(posedge clk);
    act_vector <= 8'h06;
    run();
    `CHK("new vector", 11, ack_cnt)
    @(posedge clk);
    read_skip_enable <= 1'b0;
    act_vector <= 8'h05;
  endtask : t_skip
  task automatic t_zchain;
    desc(32'h200, 8'h08, 8'hC0, 32'h0005_0000);
    run();
    `CHK("cycles", 11, ack_cnt)
    `CHK("irq", 1'b0, irq_seen)
    `CHK("fixed", 32'h340, rl(32'h208))
  endtask : t_zchain
  task automatic t_reset;
    @(posedge clk);
    act_valid <= 1'b1;
    @(posedge clk);
    act_valid <= 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b0;
    @(negedge clk);
    `CHK("rst busy", 1'b0, busy)
    `CHK("rst req", 1'b0, mem_req)
    @(posedge clk);
    nrst <= 1'b1;
    run();
    `CHK("rerun", 11, ack_cnt)
  endtask : t_reset
  task automatic report_and_stop;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop
  initial begin
    nrst = 1'b0;
    act_valid = 1'b0;
    act_vector = 8'h05;
    vector_base = 32'h100;
    read_skip_enable = 1'b0;
    slow = 2'h0;
    num_errors = 0;
    tests_run = 0;
    ack_cnt = 0;
    cyc = 0;
    irq_seen = 1'b0;
    wl(32'h114, 32'h200);
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    t_normal();
    t_split();
    t_repeat();
    t_block();
    t_chain();
    t_skip();
    t_zchain();
    t_reset();
    report_and_stop();
  end
endmodule : dte_core_tb

/* dte_mem_model.sv */
// Memory partner: answers bus cycles with optional wait states.
// Assumes one cycle at a time, byte lanes little-endian in low bits.
`timescale 1ns/100ps
module dte_mem_model (
  input  wire logic               clk,
  input  wire logic               mem_req,
  input  wire logic               mem_we,
  input  wire logic [31:0]        mem_addr,
  input  wire dte_pkg::dte_size_t mem_size,
  input  wire logic [31:0]        mem_wdata,
  input  wire logic [1:0]         slow,
  output logic                    mem_ack,
  output logic [31:0]             mem_rdata
);
  import dte_pkg::*;
  logic [7:0] mem [0:1023];
  logic [1:0] wait_cnt;
  initial begin
    mem_ack = 1'b0;
    mem_rdata = 32'h0;
    wait_cnt = 2'h0;
  end
  // ----------------------------------------
  // Bus answer, data toggles when not valid
  // ----------------------------------------
  always @(posedge clk) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (mem_req && !mem_ack) begin
      if (wait_cnt != slow) wait_cnt <= wait_cnt + 2'h1;
      else begin
        wait_cnt <= 2'h0;
        mem_ack <= 1'b1;
        for (int k = 0; k < (1 << mem_size); k++) begin
          if (mem_we) mem[mem_addr[9:0] + k] <= mem_wdata[8*k +: 8];
          else mem_rdata[8*k +: 8] <= mem[mem_addr[9:0] + k];
        end
      end
    end
  end
endmodule : dte_mem_model

/* dte_pkg.sv */
// Shared types, field layout and helpers of the descriptor transfer engine.
// Assumes a byte-addressed 32-bit memory bus with narrow data in the low bits.
package dte_pkg;

  // ---------------------------------------------------------------
  // Encodings
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    SZ_BYTE = 2'h0,
    SZ_WORD = 2'h1,
    SZ_LONG = 2'h2
  } dte_size_t;

  typedef enum logic [1:0] {
    XM_NORMAL = 2'h0,
    XM_REPEAT = 2'h1,
    XM_BLOCK  = 2'h2
  } dte_xmode_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_VEC  = 3'h1,
    ST_DESC = 3'h3,
    ST_DATA = 3'h2,
    ST_WB   = 3'h6,
    ST_DONE = 3'h7
  } dte_state_t;

  localparam logic [1:0] AM_INC = 2'h2;
  localparam logic [1:0] AM_DEC = 2'h3;

  // ---------------------------------------------------------------
  // Descriptor layout: four longwords
  // ---------------------------------------------------------------
  localparam int MRA_LSB       = 24;
  localparam int MRB_LSB       = 16;
  localparam int TCA_LSB       = 16;
  localparam int RELOAD_LSB    = 24;
  localparam int MODE_LSB      = 6;
  localparam int SIZE_LSB      = 4;
  localparam int SAM_LSB       = 2;
  localparam int CHAIN_BIT     = 7;
  localparam int ZCHAIN_BIT    = 6;
  localparam int IRQSEL_BIT    = 5;
  localparam int AREA_BIT      = 4;
  localparam int DAM_LSB       = 2;
  localparam logic [1:0]  DESC_LAST   = 2'h3;
  localparam logic [31:0] DESC_STRIDE = 32'h0000_0010;

  typedef struct packed {
    logic [7:0]  mra;
    logic [7:0]  mode_reg_b;
    logic [31:0] source_address_reg;
    logic [31:0] destination_address_reg;
    logic [15:0] tca;
    logic [15:0] btc;
  } dte_desc_t;

  typedef struct packed {
    logic [31:0] addr;
    dte_size_t   size;
    logic        we;
    logic [31:0] wdata;
  } dte_cmd_t;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [2:0] size_bytes(input dte_size_t sz);
    size_bytes = 3'h1 << sz;
  endfunction : size_bytes

  function automatic logic [31:0] addr_step(input logic [31:0] a, input logic [1:0] am, input dte_size_t sz);
    logic [31:0] d;
    d = 32'h0000_0001 << sz;
    if (am == AM_INC) addr_step = a + d;
    else if (am == AM_DEC) addr_step = a - d;
    else addr_step = a;
  endfunction : addr_step

  function automatic logic [31:0] addr_restore(input logic [31:0] a, input logic [1:0] am,
                                               input dte_size_t sz, input logic [8:0] cnt);
    logic [31:0] d;
    d = {23'h0, cnt} << sz;
    if (am == AM_INC) addr_restore = a - d;
    else if (am == AM_DEC) addr_restore = a + d;
    else addr_restore = a;
  endfunction : addr_restore

  function automatic logic [8:0] reload_count(input logic [7:0] r);
    reload_count = (r == 8'h00) ? 9'h100 : {1'b0, r};
  endfunction : reload_count

endpackage : dte_pkg

/* dte_split.sv */
// Bus cycle splitter: turns one unit access into aligned bus cycles.
// Assumes a same-clock memory bus that holds each cycle until mem_ack.
`timescale 1ns/100ps
module dte_split (
  input  logic              clk,
  input  logic              nrst,
  input  logic              cmd_valid,
  input  dte_pkg::dte_cmd_t cmd,
  output logic              cmd_ready,
  output logic              rsp_valid,
  output logic [31:0]       rsp_data,
  output logic              mem_req,
  output logic              mem_we,
  output logic [31:0]       mem_addr,
  output dte_pkg::dte_size_t mem_size,
  output logic [31:0]       mem_wdata,
  input  logic              mem_ack,
  input  logic [31:0]       mem_rdata
);
  import dte_pkg::*;

  typedef struct packed {
    logic        active;
    logic        done;
    logic [31:0] base;
    logic [2:0]  total;
    logic [2:0]  off;
    logic        we;
    logic [31:0] wdata;
    logic [31:0] acc;
    logic [31:0] sub_addr;
    dte_size_t   sub_size;
    logic [31:0] sub_wdata;
  } dte_split_st_t;

  dte_split_st_t s_reg;
  dte_split_st_t s_next;

  // Largest aligned cycle that fits the bytes left
  function automatic dte_size_t pick(input logic [31:0] a, input logic [2:0] left);
    if (a[0] || left == 3'h1) pick = SZ_BYTE;
    else if (!a[1] && left == 3'h4) pick = SZ_LONG;
    else pick = SZ_WORD;
  endfunction : pick

  function automatic logic [31:0] lane_mask(input dte_size_t sz);
    lane_mask = (sz == SZ_BYTE) ? 32'h0000_00FF : (sz == SZ_WORD) ? 32'h0000_FFFF : 32'hFFFF_FFFF;
  endfunction : lane_mask

  assign cmd_ready = !s_reg.active;
  assign rsp_valid = s_reg.done;
  assign rsp_data  = s_reg.acc;
  assign mem_req   = s_reg.active;
  assign mem_we    = s_reg.we;
  assign mem_addr  = s_reg.sub_addr;
  assign mem_size  = s_reg.sub_size;
  assign mem_wdata = s_reg.sub_wdata;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [2:0]  off_n;
    logic [31:0] a_n;
    off_n = 3'h0;
    a_n = 32'h0;
    s_next = s_reg;
    s_next.done = 1'b0;
    if (!s_reg.active && cmd_valid) begin
      s_next.active = 1'b1;
      s_next.base = cmd.addr;
      s_next.total = size_bytes(cmd.size);
      s_next.off = 3'h0;
      s_next.we = cmd.we;
      s_next.wdata = cmd.wdata;
      s_next.acc = 32'h0;
      s_next.sub_addr = cmd.addr;
      s_next.sub_size = pick(cmd.addr, size_bytes(cmd.size));
      s_next.sub_wdata = cmd.wdata;
    end else if (s_reg.active && mem_ack) begin
      off_n = s_reg.off + size_bytes(s_reg.sub_size);
      a_n = s_reg.base + {29'h0, off_n};
      s_next.off = off_n;
      s_next.acc = s_reg.acc | ((mem_rdata & lane_mask(s_reg.sub_size)) << {s_reg.off, 3'h0});
      if (off_n == s_reg.total) begin
        s_next.active = 1'b0;
        s_next.done = 1'b1;
      end else begin
        s_next.sub_addr = a_n;
        s_next.sub_size = pick(a_n, s_reg.total - off_n);
        s_next.sub_wdata = s_reg.wdata >> {off_n, 3'h0};
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

endmodule : dte_split
